// ---- pkg/eitl_pkg.sv ----
// Purpose: Shared constants and types for the interrupt and trap block
// Assumes: 25 MHz high-frequency clock, byte-wide stack memory
// Notes:   Register word index times four gives the Wishbone byte address
package eitl_pkg;

	// Register word indices
	localparam logic [7:0] EITL_IDX_EXT_CTRL = 8'h37;
	localparam logic [7:0] EITL_IDX_IRQ_EN   = 8'h38;
	localparam logic [7:0] EITL_IDX_LATCH    = 8'h39;
	localparam logic [7:0] EITL_IDX_TRAP     = 8'h3A;
	localparam logic [7:0] EITL_IDX_SP       = 8'h3B;

	// External interrupt control field positions
	localparam int EITL_B_NOISE1 = 7;
	localparam int EITL_B_PINFN0 = 6;
	localparam int EITL_B_EDGE3  = 3;
	localparam int EITL_B_EDGE2  = 2;
	localparam int EITL_B_EDGE1  = 1;
	localparam logic [7:0] EITL_EXT_CTRL_MASK = 8'hCE;
	localparam logic [7:0] EITL_EXT_CTRL_RST  = 8'h00;

	// Enable register: bit 0 master, bits 5..1 lines 0,1,2,3,5
	localparam int EITL_B_MASTER = 0;
	localparam logic [5:0] EITL_IRQ_EN_RST = 6'h00;

	// Status word bit holding the master enable
	localparam int EITL_STAT_MASTER = 0;

	// Filter thresholds in samples (fc periods, or fs ticks when slow)
	localparam logic [7:0] EITL_FLT_L05   = 8'h04;
	localparam logic [7:0] EITL_FLT_L1_LO = 8'h60;
	localparam logic [7:0] EITL_FLT_L1_HI = 8'h18;
	localparam logic [7:0] EITL_FLT_L23   = 8'h0C;
	localparam logic [7:0] EITL_FLT_SLOW  = 8'h02;

	// Acceptance and return timing in cycles
	localparam logic [2:0] EITL_ACC_LAST = 3'h7;
	localparam logic [2:0] EITL_RET_LAST = 3'h4;

	// Fetch value that decodes as the soft trap opcode
	localparam logic [7:0] EITL_SOFT_TRAP_CODE = 8'hFF;

	// Fetch address areas that trap
	localparam logic [15:0] EITL_REGS_LO = 16'h0000;
	localparam logic [15:0] EITL_REGS_HI = 16'h003F;
	localparam logic [15:0] EITL_BUFA_LO = 16'h0F80;
	localparam logic [15:0] EITL_BUFA_HI = 16'h0FFF;

	// Accepted source codes
	typedef enum logic [3:0] {
		EITL_SRC_NONE  = 4'h0,
		EITL_SRC_SOFT  = 4'h1,
		EITL_SRC_UNDEF = 4'h2,
		EITL_SRC_TRAP  = 4'h3,
		EITL_SRC_L0    = 4'h4,
		EITL_SRC_L1    = 4'h5,
		EITL_SRC_L2    = 4'h6,
		EITL_SRC_L3    = 4'h7,
		EITL_SRC_L5    = 4'h8
	} eitl_src_e;

	// Saved machine context
	typedef struct packed {
		logic [7:0]  stat;
		logic [15:0] pc;
	} eitl_frame_s;

	// Sequencer states
	typedef enum logic [1:0] {
		EITL_ST_IDLE   = 2'b00,
		EITL_ST_ACCEPT = 2'b01,
		EITL_ST_RETURN = 2'b11
	} eitl_state_e;

endpackage : eitl_pkg

// ---- rtl/eitl_noise_filter.sv ----
// Purpose: Digital noise filter for one external interrupt line
// Assumes: Input already synchronised to clk
// Notes:   Output flips after thresh stable samples of the new level
`timescale 1ns/10ps
module eitl_noise_filter
	import eitl_pkg::*;
#(
	parameter int CW = 8
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          resetn,
	// Sample control
	input  wire logic          sample_en,
	input  wire logic [CW-1:0] thresh,
	// Line
	input  wire logic          line_in,
	output logic               line_out
);

	logic [CW-1:0] cnt_reg;

	// Count stable samples of the opposite level
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg  <= '0;
			line_out <= 1'b1;
		end else if (line_in == line_out) begin
			cnt_reg <= '0;
		end else if (sample_en) begin
			if (cnt_reg + 1'b1 >= thresh) begin
				line_out <= line_in;
				cnt_reg  <= '0;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

endmodule : eitl_noise_filter

// ---- rtl/eitl_stack_mem.sv ----
// Purpose: Byte-wide stack memory for saved context
// Assumes: One access per cycle, write has priority
// Notes:   Read data is registered, one cycle after the address
`timescale 1ns/10ps
module eitl_stack_mem #(
	parameter int AW = 8
) (
	// Clock
	input  wire logic          clk,
	// Access
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic [7:0]         rdata
);

	logic [7:0] mem [0:(1<<AW)-1];

	// Single port, registered read
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule : eitl_stack_mem

// ---- rtl/eitl_ext_irq.sv ----
// Purpose: External interrupt lines, trap detection, accept and return
// Assumes: Core pulses are one cycle, on clk; pins are asynchronous
// Notes:   Wishbone classic slave, one wait state per access
//
// Contract
// - Return restores PC, status, master enable; SP+3
// - Saved PC low at SP+1, high at SP+2
// - Pending requests sampled in instruction last cycle
// - Soft trap opcode starts processing, top priority
// - Missing-memory fetch returns FFH in single chip
// - Fetch from RAM, buffer, register area traps
// - Trap gives reset or interrupt per selection
// - Undefined opcode interrupts at once, even NMI
// - Address trap accepted at once, even NMI
// - Five external lines, each noise filtered
// - Line zero pin is port after reset
// - Line zero falling edge, gated by pin function
// - Lines one to three edge selectable
// - Lines zero, five: reject 2, accept 7
// - Line one filter 63/193 or 15/49
// - Lines two, three: reject 7, accept 25
// - Slow modes: reject 1 fs, accept 3.5 fs
// - Clean edge latched within settle plus 6 fs
// - Noise select change active within 26 fc
// - Output changes on shared pin may fake requests
// - Accept takes 8 cycles, clears master and latch
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
module eitl_ext_irq
	import eitl_pkg::*;
#(
	parameter logic [15:0] RAM_LO = 16'h0040,
	parameter logic [15:0] RAM_HI = 16'h083F
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// Wishbone slave
	input  wire logic         cyc_i,
	input  wire logic         stb_i,
	input  wire logic         we_i,
	input  wire logic [31:0]  adr_i,
	input  wire logic [3:0]   sel_i,
	input  wire logic [31:0]  dat_i,
	output logic [31:0]       dat_o,
	output logic              ack_o,
	// External pins, asynchronous
	input  wire logic [4:0]   ext_lines,
	// Low-frequency mode and tick
	input  wire logic         slow_mode,
	input  wire logic         fs_tick,
	// Core sequencing
	input  wire logic         core_last_cycle,
	input  wire logic         core_soft_trap,
	input  wire logic         core_undef_op,
	input  wire logic         core_return,
	input  wire logic         core_fetch,
	input  wire logic [15:0]  core_fetch_addr,
	input  wire logic         core_fetch_missing,
	input  wire logic         single_chip,
	input  wire eitl_frame_s  core_ctx,
	// Core answers
	output logic              fetch_force,
	output logic [7:0]        fetch_force_data,
	output logic              vector_valid,
	output logic [3:0]        vector_src,
	output logic              return_done,
	output eitl_frame_s       return_ctx,
	output logic              trap_reset,
	output logic              shared_port_bit
);

	// Registers
	logic [7:0]  ext_ctrl_reg;
	logic [5:0]  irq_en_reg;
	logic [4:0]  latch_reg;
	logic        trap_sel_reg;
	logic [7:0]  sp_reg;
	eitl_state_e state_reg;
	logic [2:0]  step_reg;
	eitl_src_e   src_reg;
	eitl_frame_s ctx_reg;
	logic [4:0]  sync1_reg;
	logic [4:0]  sync2_reg;
	logic [4:0]  filt_prev_reg;

	// Wires
	logic [4:0]  filt;
	logic [4:0]  edge_hit;
	logic [7:0]  th [0:4];
	logic        smp_en;
	logic        wb_go;
	logic [7:0]  idx;
	logic        trap_area;
	logic        trap_hit;
	logic [4:0]  pend;
	eitl_src_e   pick_next;
	logic        acc_start;
	logic        mem_we;
	logic [7:0]  mem_addr;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;
	logic [4:0]  clr_sw;
	logic [4:0]  clr_hw;

	assign wb_go = cyc_i && stb_i && !ack_o;
	assign idx   = adr_i[9:2];

	// Two-flop pin synchronisers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_reg <= 5'h1F;
			sync2_reg <= 5'h1F;
		end else begin
			sync1_reg <= ext_lines;
			sync2_reg <= sync1_reg;
		end
	end

	// Port read of the shared pin, active from reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shared_port_bit <= 1'b1;
		end else begin
			shared_port_bit <= sync2_reg[0];
		end
	end

	// Filter thresholds; slow mode counts fs ticks
	assign smp_en = slow_mode ? fs_tick : 1'b1;
	always_comb begin
		th[0] = EITL_FLT_L05;
		th[4] = EITL_FLT_L05;
		th[1] = ext_ctrl_reg[EITL_B_NOISE1] ? EITL_FLT_L1_HI
			: EITL_FLT_L1_LO;
		th[2] = EITL_FLT_L23;
		th[3] = EITL_FLT_L23;
		if (slow_mode) begin
			for (int i = 0; i < 5; i++) begin
				th[i] = EITL_FLT_SLOW;
			end
		end
	end

	// One filter per external line
	for (genvar g = 0; g < 5; g++) begin : g_flt
		eitl_noise_filter #(
			.CW (8)
		) u_flt (
			.clk       (clk),
			.resetn    (resetn),
			.sample_en (smp_en),
			.thresh    (th[g]),
			.line_in   (sync2_reg[g]),
			.line_out  (filt[g])
		);
	end

	// Previous filtered level for edge detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			filt_prev_reg <= 5'h1F;
		end else begin
			filt_prev_reg <= filt;
		end
	end

	// Edge detection per line
	always_comb begin
		edge_hit[0] = filt_prev_reg[0] && !filt[0]
			&& ext_ctrl_reg[EITL_B_PINFN0];
		edge_hit[1] = ext_ctrl_reg[EITL_B_EDGE1]
			? (filt_prev_reg[1] && !filt[1])
			: (!filt_prev_reg[1] && filt[1]);
		edge_hit[2] = ext_ctrl_reg[EITL_B_EDGE2]
			? (filt_prev_reg[2] && !filt[2])
			: (!filt_prev_reg[2] && filt[2]);
		edge_hit[3] = ext_ctrl_reg[EITL_B_EDGE3]
			? (filt_prev_reg[3] && !filt[3])
			: (!filt_prev_reg[3] && filt[3]);
		edge_hit[4] = filt_prev_reg[4] && !filt[4];
	end

	// Trap areas of the fetch address
	assign trap_area =
		(core_fetch_addr <= EITL_REGS_HI)
		|| (core_fetch_addr >= RAM_LO && core_fetch_addr <= RAM_HI)
		|| (core_fetch_addr >= EITL_BUFA_LO
			&& core_fetch_addr <= EITL_BUFA_HI);
	assign trap_hit = core_fetch && trap_area;

	// Pending maskable lines and source choice
	assign pend = latch_reg & irq_en_reg[5:1];
	always_comb begin
		pick_next = EITL_SRC_NONE;
		if (core_soft_trap) begin
			pick_next = EITL_SRC_SOFT;
		end else if (core_undef_op) begin
			pick_next = EITL_SRC_UNDEF;
		end else if (trap_hit && !trap_sel_reg) begin
			pick_next = EITL_SRC_TRAP;
		end else if (core_last_cycle
			&& irq_en_reg[EITL_B_MASTER]) begin
			if (pend[0]) begin
				pick_next = EITL_SRC_L0;
			end else if (pend[1]) begin
				pick_next = EITL_SRC_L1;
			end else if (pend[2]) begin
				pick_next = EITL_SRC_L2;
			end else if (pend[3]) begin
				pick_next = EITL_SRC_L3;
			end else if (pend[4]) begin
				pick_next = EITL_SRC_L5;
			end
		end
	end
	assign acc_start = (pick_next != EITL_SRC_NONE)
		&& (state_reg == EITL_ST_IDLE
			|| pick_next == EITL_SRC_UNDEF
			|| pick_next == EITL_SRC_TRAP);

	// Latch clear by software write of zero and by acceptance
	always_comb begin
		clr_sw = '0;
		clr_hw = '0;
		if (wb_go && we_i && sel_i[0] && idx == EITL_IDX_LATCH) begin
			clr_sw = ~dat_i[4:0];
		end
		if (state_reg == EITL_ST_ACCEPT && step_reg == 3'h0) begin
			case (src_reg)
				EITL_SRC_L0: clr_hw = 5'h01;
				EITL_SRC_L1: clr_hw = 5'h02;
				EITL_SRC_L2: clr_hw = 5'h04;
				EITL_SRC_L3: clr_hw = 5'h08;
				EITL_SRC_L5: clr_hw = 5'h10;
				default:     clr_hw = 5'h00;
			endcase
		end
	end

	// Interrupt latches; a new edge wins over a clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			latch_reg <= '0;
		end else begin
			latch_reg <= (latch_reg & ~(clr_sw | clr_hw))
				| edge_hit;
		end
	end

	// Control register and trap selection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ext_ctrl_reg <= EITL_EXT_CTRL_RST;
			trap_sel_reg <= 1'b0;
		end else if (wb_go && we_i && sel_i[0]) begin
			if (idx == EITL_IDX_EXT_CTRL) begin
				ext_ctrl_reg <= dat_i[7:0]
					& EITL_EXT_CTRL_MASK;
			end
			if (idx == EITL_IDX_TRAP) begin
				trap_sel_reg <= dat_i[0];
			end
		end
	end

	// Enable flags; hardware acceptance and return override writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_en_reg <= EITL_IRQ_EN_RST;
		end else begin
			if (wb_go && we_i && sel_i[0]
				&& idx == EITL_IDX_IRQ_EN) begin
				irq_en_reg <= dat_i[5:0];
			end
			if (state_reg == EITL_ST_ACCEPT && step_reg == 3'h0) begin
				irq_en_reg[EITL_B_MASTER] <= 1'b0;
			end
			if (state_reg == EITL_ST_RETURN
				&& step_reg == EITL_RET_LAST) begin
				irq_en_reg[EITL_B_MASTER] <=
					ctx_reg.stat[EITL_STAT_MASTER];
			end
		end
	end

	// Sequencer for acceptance and return
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= EITL_ST_IDLE;
			step_reg  <= '0;
			src_reg   <= EITL_SRC_NONE;
		end else begin
			case (state_reg)
				EITL_ST_IDLE: begin
					step_reg <= '0;
					if (acc_start) begin
						state_reg <= EITL_ST_ACCEPT;
						src_reg   <= pick_next;
					end else if (core_return) begin
						state_reg <= EITL_ST_RETURN;
					end
				end
				EITL_ST_ACCEPT: begin
					if (acc_start && (pick_next == EITL_SRC_UNDEF
						|| pick_next == EITL_SRC_TRAP)) begin
						src_reg  <= pick_next;
						step_reg <= '0;
					end else if (step_reg == EITL_ACC_LAST) begin
						state_reg <= EITL_ST_IDLE;
					end else begin
						step_reg <= step_reg + 3'h1;
					end
				end
				EITL_ST_RETURN: begin
					if (step_reg == EITL_RET_LAST) begin
						state_reg <= EITL_ST_IDLE;
					end else begin
						step_reg <= step_reg + 3'h1;
					end
				end
				default: begin
					state_reg <= EITL_ST_IDLE;
				end
			endcase
		end
	end

	// Context capture on acceptance, restore from stack on return
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctx_reg <= '0;
		end else if (state_reg == EITL_ST_IDLE && acc_start) begin
			ctx_reg     <= core_ctx;
			ctx_reg.stat[EITL_STAT_MASTER] <=
				irq_en_reg[EITL_B_MASTER];
		end else if (state_reg == EITL_ST_RETURN) begin
			case (step_reg)
				3'h1: ctx_reg.pc[7:0]  <= mem_rdata;
				3'h2: ctx_reg.pc[15:8] <= mem_rdata;
				3'h3: ctx_reg.stat     <= mem_rdata;
				default: ctx_reg <= ctx_reg;
			endcase
		end
	end

	// Stack port: push status, high, low; pop low, high, status
	always_comb begin
		mem_we    = 1'b0;
		mem_addr  = sp_reg;
		mem_wdata = ctx_reg.stat;
		if (state_reg == EITL_ST_ACCEPT) begin
			case (step_reg)
				3'h1: begin
					mem_we = 1'b1;
				end
				3'h2: begin
					mem_we    = 1'b1;
					mem_addr  = sp_reg - 8'h01;
					mem_wdata = ctx_reg.pc[15:8];
				end
				3'h3: begin
					mem_we    = 1'b1;
					mem_addr  = sp_reg - 8'h02;
					mem_wdata = ctx_reg.pc[7:0];
				end
				default: mem_we = 1'b0;
			endcase
		end else if (state_reg == EITL_ST_RETURN) begin
			mem_addr = sp_reg + {5'h00, step_reg} + 8'h01;
		end
	end

	eitl_stack_mem #(
		.AW (8)
	) u_stack (
		.clk   (clk),
		.we    (mem_we),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (mem_rdata)
	);

	// Stack pointer: down three on push, up three on return
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sp_reg <= '0;
		end else if (state_reg == EITL_ST_ACCEPT
			&& step_reg == 3'h3) begin
			sp_reg <= sp_reg - 8'h03;
		end else if (state_reg == EITL_ST_RETURN
			&& step_reg == EITL_RET_LAST) begin
			sp_reg <= sp_reg + 8'h03;
		end else if (wb_go && we_i && sel_i[0]
			&& idx == EITL_IDX_SP && state_reg == EITL_ST_IDLE) begin
			sp_reg <= dat_i[7:0];
		end
	end

	// Core answer pulses
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vector_valid <= 1'b0;
			vector_src   <= '0;
			return_done  <= 1'b0;
			return_ctx   <= '0;
			trap_reset   <= 1'b0;
		end else begin
			vector_valid <= state_reg == EITL_ST_ACCEPT
				&& step_reg == EITL_ACC_LAST;
			vector_src   <= src_reg;
			return_done  <= state_reg == EITL_ST_RETURN
				&& step_reg == EITL_RET_LAST;
			return_ctx   <= ctx_reg;
			trap_reset   <= trap_hit && trap_sel_reg;
		end
	end

	// Forced fetch data for missing memory
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fetch_force      <= 1'b0;
			fetch_force_data <= '0;
		end else begin
			fetch_force      <= core_fetch && core_fetch_missing
				&& single_chip;
			fetch_force_data <= EITL_SOFT_TRAP_CODE;
		end
	end

	// Wishbone answer one cycle after the request
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= wb_go;
			dat_o <= '0;
			if (wb_go && !we_i) begin
				case (idx)
					EITL_IDX_EXT_CTRL: dat_o[7:0] <= ext_ctrl_reg;
					EITL_IDX_IRQ_EN:   dat_o[5:0] <= irq_en_reg;
					EITL_IDX_LATCH:    dat_o[4:0] <= latch_reg;
					EITL_IDX_TRAP: begin
						dat_o[0]   <= trap_sel_reg;
						dat_o[7:4] <= src_reg;
					end
					EITL_IDX_SP:       dat_o[7:0] <= sp_reg;
					default:           dat_o <= '0;
				endcase
			end
		end
	end

endmodule : eitl_ext_irq

// ---- sim/eitl_ext_irq_asserts.sv ----
// Purpose: Port checks for the interrupt and trap block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Vector and return timing counted from the request edge
`timescale 1ns/10ps
module eitl_ext_irq_asserts
	import eitl_pkg::*;
#(
	parameter logic [15:0] RAM_LO = 16'h0040,
	parameter logic [15:0] RAM_HI = 16'h083F
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Bus
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	// Pins and core requests
	input wire logic [4:0]  ext_lines,
	input wire logic        core_soft_trap,
	input wire logic        core_undef_op,
	input wire logic        core_return,
	input wire logic        core_fetch,
	input wire logic [15:0] core_fetch_addr,
	input wire logic        core_fetch_missing,
	input wire logic        single_chip,
	// Answers
	input wire logic        fetch_force,
	input wire logic [7:0]  fetch_force_data,
	input wire logic        vector_valid,
	input wire logic [3:0]  vector_src,
	input wire logic        return_done,
	input wire logic        trap_reset,
	input wire logic        shared_port_bit
);
	logic trap_hit;
	logic miss_hit;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Fetch into a trapping area, fetch from nowhere
	assign trap_hit = core_fetch && (core_fetch_addr <= EITL_REGS_HI
		|| (core_fetch_addr >= RAM_LO && core_fetch_addr <= RAM_HI)
		|| (core_fetch_addr >= EITL_BUFA_LO
		&& core_fetch_addr <= EITL_BUFA_HI));
	assign miss_hit = core_fetch && core_fetch_missing && single_chip;

	// Return: five quiet cycles, then done
	sequence s_ret;
		(!return_done) [*5] ##1 return_done;
	endsequence
	// Vector after eight steps and the output flop
	sequence s_vec_undef;
		##9 (vector_valid && vector_src == EITL_SRC_UNDEF);
	endsequence

	property p_ack;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus request not acknowledged");
	property p_force;
		miss_hit |=> fetch_force && fetch_force_data == EITL_SOFT_TRAP_CODE;
	endproperty
	a_force: assert property (p_force)
		else $error("missing fetch not forced to soft trap");
	property p_trap_rst;
		trap_reset |-> $past(trap_hit);
	endproperty
	a_trap_rst: assert property (p_trap_rst)
		else $error("trap reset without trapping fetch");
	property p_ret;
		core_return |=> s_ret;
	endproperty
	a_ret: assert property (p_ret)
		else $error("return not done on time");
	property p_undef;
		core_undef_op && !core_soft_trap |-> s_vec_undef;
	endproperty
	a_undef: assert property (p_undef)
		else $error("undefined opcode not vectored");
	property p_prio;
		core_soft_trap && core_undef_op
			|-> ##9 (vector_valid && vector_src == EITL_SRC_SOFT);
	endproperty
	a_prio: assert property (p_prio)
		else $error("soft trap lost priority");
	property p_swi_src;
		vector_valid && vector_src == EITL_SRC_SOFT
			|-> $past(core_soft_trap, 9);
	endproperty
	a_swi_src: assert property (p_swi_src)
		else $error("soft trap vector without request");
	property p_trap_src;
		vector_valid && vector_src == EITL_SRC_TRAP |-> $past(trap_hit, 9);
	endproperty
	a_trap_src: assert property (p_trap_src)
		else $error("trap vector without trapping fetch");
	property p_port;
		$fell(ext_lines[0]) |-> ##[1:3] !shared_port_bit;
	endproperty
	a_port: assert property (p_port)
		else $error("port bit does not follow pin");
endmodule : eitl_ext_irq_asserts

bind eitl_ext_irq eitl_ext_irq_asserts #(
	.RAM_LO(RAM_LO),
	.RAM_HI(RAM_HI)
) i_eitl_ext_irq_asserts (
	.clk, .resetn, .cyc_i, .stb_i, .ack_o, .ext_lines, .core_soft_trap,
	.core_undef_op, .core_return, .core_fetch, .core_fetch_addr,
	.core_fetch_missing, .single_chip, .fetch_force, .fetch_force_data,
	.vector_valid, .vector_src, .return_done, .trap_reset, .shared_port_bit
);

// ---- sim/eitl_pin_src.sv ----
// Purpose: Signal source model for the five external lines
// Assumes: Lines idle high, as with a pull-up
// Notes:   One low pulse of len cycles per request, then released
`timescale 1ns/10ps
module eitl_pin_src (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// Request
	input  wire logic       go,
	input  wire logic [2:0] line,
	input  wire logic [7:0] len,
	// Pins
	output logic [4:0]      ext_lines
);
	logic [7:0] cnt_reg;

	// Low pulse on one line, back to idle high after len cycles
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg   <= 8'h00;
			ext_lines <= 5'h1F;
		end else if (go) begin
			cnt_reg   <= len;
			ext_lines <= ~(5'h01 << line);
		end else if (cnt_reg > 8'h01) begin
			cnt_reg <= cnt_reg - 8'h01;
		end else begin
			cnt_reg   <= 8'h00;
			ext_lines <= 5'h1F;
		end
	end
endmodule : eitl_pin_src

// ---- sim/ext_interrupt_and_trap_logic_bench.sv ----
// Purpose: Self-checking bench for the interrupt and trap block
// Assumes: 25 MHz clock, pins driven by the pin source model
// Notes:   Random noise pulses come from a fixed seed
`timescale 1ns/10ps
module ext_interrupt_and_trap_logic_bench;
	import eitl_pkg::*;
	localparam logic [15:0] RLO = 16'h0040;
	localparam logic [15:0] RHI = 16'h083F;
	logic clk = 1'b0, resetn = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [31:0] adr_i = 32'h0000_0000, dat_i = 32'h0000_0000, dat_o;
	logic [3:0] sel_i = 4'h1, vector_src;
	logic slow_mode = 1'b0, fs_tick = 1'b0, single_chip = 1'b0, go = 1'b0;
	logic core_fetch_missing = 1'b0, core_last_cycle, core_soft_trap;
	logic core_undef_op, core_return, core_fetch, ack_o, fetch_force;
	logic vector_valid, return_done, trap_reset, shared_port_bit;
	logic [4:0] req = 5'h00, ext_lines;
	logic [2:0] fs_cnt = 3'h0, pin_line = 3'h0;
	logic [7:0] pin_len = 8'h01, fetch_force_data;
	logic [15:0] core_fetch_addr = 16'h0000;
	eitl_frame_s core_ctx = 24'h00_0000, return_ctx;
	int mismatches = 0, compares = 0, seed;

	eitl_ext_irq #(.RAM_LO(RLO), .RAM_HI(RHI)) i_eitl_ext_irq (.clk, .resetn,
		.cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.ext_lines, .slow_mode, .fs_tick, .core_last_cycle, .core_soft_trap,
		.core_undef_op, .core_return, .core_fetch, .core_fetch_addr,
		.core_fetch_missing, .single_chip, .core_ctx, .fetch_force,
		.fetch_force_data, .vector_valid, .vector_src, .return_done,
		.return_ctx, .trap_reset, .shared_port_bit);
	eitl_pin_src i_eitl_pin_src (.clk, .resetn, .go, .line(pin_line),
		.len(pin_len), .ext_lines);

	// Clock, low-frequency tick and core request bits
	always #20 clk = ~clk;
	always @(posedge clk) begin
		fs_cnt  <= fs_cnt + 3'h1;
		fs_tick <= (fs_cnt == 3'h7);
	end
	assign {core_fetch, core_return, core_undef_op, core_soft_trap,
		core_last_cycle} = req;

	// Longest pulse that must be dropped as noise
	function automatic int rej(input int k, input bit nb);
		if (k == 1) return nb ? 14 : 62;
		return (k == 2 || k == 3) ? 6 : 1;
	endfunction : rej
	// Latch bits expected once only the falling edge has passed
	function automatic logic [7:0] fall_exp(input int k, input bit es);
		return (k == 0 || k == 4 || es) ? 8'h01 << k : 8'h00;
	endfunction : fall_exp
	// Fetch addresses that must trap
	function automatic logic trap_exp(input logic [15:0] a);
		return a <= 16'h003F || (a >= RLO && a <= RHI)
			|| (a >= 16'h0F80 && a <= 16'h0FFF);
	endfunction : trap_exp
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	task automatic bound(input int i);
		if (i >= 30) begin
			mismatches++;
			$display("ERROR %0t: wait ran out", $time);
			give_verdict();
		end
	endtask : bound
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// Classic Wishbone cycle, held until ack is seen
	task automatic wb(input logic w, input logic [7:0] idx,
		input logic [7:0] d, output logic [7:0] q);
		int i;
		@(posedge clk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {22'h00_0000, idx, 2'b00};
		dat_i <= {24'h00_0000, d};
		i = 0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (ack_o !== 1'b1 && i < 30);
		bound(i);
		q = dat_o[7:0];
		@(posedge clk);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, idx, d, q);
	endtask : wr
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		wb(1'b0, idx, 8'h00, q);
		chk(q, exp);
	endtask : rdc
	task automatic pulse(input int k, input int n);
		@(posedge clk);
		go       <= 1'b1;
		pin_line <= k[2:0];
		pin_len  <= n[7:0];
		@(posedge clk);
		go <= 1'b0;
	endtask : pulse
	task automatic fire(input logic [4:0] m, input logic [15:0] a);
		@(posedge clk);
		req             <= m;
		core_fetch_addr <= a;
	endtask : fire
	// Count edges until the vector or the return completes
	task automatic wait_ev(input bit ret, output int i);
		i = 0;
		do begin
			@(posedge clk);
			req <= 5'h00;
			#1;
			i++;
		end while ((ret ? return_done : vector_valid) !== 1'b1 && i < 30);
		bound(i);
	endtask : wait_ev

	// Main sequence
	initial begin
		int          i;
		int          k;
		int          n;
		bit          nb;
		logic [15:0] ta [8];
		ta = '{16'h003F, 16'h0040, 16'h083F, 16'h0840,
			16'h0F7F, 16'h0F80, 16'h0FFF, 16'h1000};
		seed = 1578;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		tick(2);
		chk(shared_port_bit, 1'b1);
		rdc(EITL_IDX_EXT_CTRL, 8'h00);
		rdc(8'h10, 8'h00);
		wr(EITL_IDX_EXT_CTRL, 8'hFF);
		rdc(EITL_IDX_EXT_CTRL, 8'hCE);
		wr(EITL_IDX_EXT_CTRL, 8'h80);
		pulse(0, 20);
		tick(40);
		rdc(EITL_IDX_LATCH, 8'h00);
		for (k = 0; k < 5; k++) begin
			for (n = 0; n < 2; n++) begin
				wr(EITL_IDX_EXT_CTRL, 8'hC0 | (8'(n) << k));
				pulse(k, 150);
				tick(70);
				rdc(EITL_IDX_LATCH, fall_exp(k, n[0]));
				tick(150);
				rdc(EITL_IDX_LATCH, 8'h01 << k);
				wr(EITL_IDX_LATCH, 8'h00);
			end
		end
		for (n = 0; n < 12; n++) begin
			k  = $unsigned($random(seed)) % 5;
			nb = 1'($random(seed));
			wr(EITL_IDX_EXT_CTRL, {nb, 7'h4E});
			tick(30);
			pulse(k, 1 + $unsigned($random(seed)) % rej(k, nb));
			tick(120);
			rdc(EITL_IDX_LATCH, 8'h00);
		end
		wr(EITL_IDX_EXT_CTRL, 8'h42);
		tick(30);
		pulse(1, 193);
		tick(190);
		rdc(EITL_IDX_LATCH, 8'h02);
		wr(EITL_IDX_LATCH, 8'h00);
		slow_mode <= 1'b1;
		pulse(2, 6);
		tick(60);
		rdc(EITL_IDX_LATCH, 8'h00);
		pulse(2, 28);
		tick(60);
		rdc(EITL_IDX_LATCH, 8'h04);
		wr(EITL_IDX_LATCH, 8'h00);
		slow_mode <= 1'b0;
		wr(EITL_IDX_EXT_CTRL, 8'h40);
		wr(EITL_IDX_SP, 8'h80);
		wr(EITL_IDX_IRQ_EN, 8'h22);
		wr(EITL_IDX_IRQ_EN, 8'h23);
		pulse(0, 20);
		tick(40);
		pulse(4, 20);
		tick(40);
		core_ctx <= 24'h01_1234;
		fire(5'h01, 16'h0000);
		wait_ev(1'b0, i);
		chk(i, 9);
		chk(vector_src, EITL_SRC_L0);
		rdc(EITL_IDX_LATCH, 8'h10);
		rdc(EITL_IDX_IRQ_EN, 8'h22);
		rdc(EITL_IDX_SP, 8'h7D);
		fire(5'h08, 16'h0000);
		wait_ev(1'b1, i);
		chk(i, 6);
		chk(return_ctx, 24'h01_1234);
		fire(5'h01, 16'h0000);
		wait_ev(1'b0, i);
		chk(vector_src, EITL_SRC_L5);
		rdc(EITL_IDX_SP, 8'h7D);
		wr(EITL_IDX_IRQ_EN, 8'h23);
		pulse(0, 20);
		tick(40);
		fire(5'h07, 16'h0000);
		wait_ev(1'b0, i);
		chk(vector_src, EITL_SRC_SOFT);
		fire(5'h02, 16'h0000);
		fire(5'h04, 16'h0000);
		wait_ev(1'b0, i);
		chk(i, 9);
		chk(vector_src, EITL_SRC_UNDEF);
		wr(EITL_IDX_TRAP, 8'h00);
		fire(5'h02, 16'h0000);
		fire(5'h10, 16'h0F80);
		wait_ev(1'b0, i);
		chk(vector_src, EITL_SRC_TRAP);
		wr(EITL_IDX_SP, 8'h77);
		wr(EITL_IDX_TRAP, 8'h01);
		foreach (ta[j]) begin
			fire(5'h10, ta[j]);
			fire(5'h00, ta[j]);
			#1;
			chk(trap_reset, trap_exp(ta[j]));
			tick(3);
		end
		core_fetch_missing <= 1'b1;
		for (n = 0; n < 2; n++) begin
			single_chip <= n[0];
			fire(5'h10, 16'h4000);
			fire(5'h00, 16'h4000);
			#1;
			chk(fetch_force, n[0]);
			chk(n[0] ? fetch_force_data : 8'hFF, 8'hFF);
		end
		give_verdict();
	end
endmodule : ext_interrupt_and_trap_logic_bench
